// ===== common/fesc_params.svh
// Constants for the flash erase/write/suspend host controller.
// Assumes a byte-wide flash driven through write and output strobes.
`ifndef FESC_PARAMS_SVH
`define FESC_PARAMS_SVH

// ===========================================================
// Flash command codes
`define FESC_CMD_READ_ARRAY 8'hff
`define FESC_CMD_READ_STATUS 8'h70
`define FESC_CMD_CLEAR_STATUS 8'h50
`define FESC_CMD_ERASE_SETUP 8'h20
`define FESC_CMD_CONFIRM 8'hd0
`define FESC_CMD_WRITE_SETUP 8'h40
`define FESC_CMD_WRITE_SETUP_ALT 8'h10
`define FESC_CMD_SUSPEND 8'hb0
`define FESC_CMD_RESUME 8'hd0

// ===========================================================
// Flash status bit positions
`define FESC_SR_READY 7
`define FESC_SR_ERASE_SUSP 6
`define FESC_SR_ERASE_ERR 5
`define FESC_SR_WRITE_ERR 4
`define FESC_SR_SUPPLY_LOW 3
`define FESC_SR_WRITE_SUSP 2
`define FESC_SR_LOCK_VIOL 1

// ===========================================================
// Avalon register byte offsets
`define FESC_REG_CTRL 4'h0
`define FESC_REG_ADDR 4'h4
`define FESC_REG_DATA 4'h8
`define FESC_REG_STAT 4'hc

// ===========================================================
// Control register fields (write of CTRL starts an operation)
`define FESC_OP_LSB 0
`define FESC_CTRL_ALT_SETUP 4

// ===========================================================
// Strobe timing: each strobe phase in ns, and cycles at 40 ns
`define FESC_PHASE_NS 80
`define FESC_CLK_NS 40
`define FESC_PHASE_CYC ((`FESC_PHASE_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS)

`endif

// ===== common/fesc_pkg.sv
// Types for the flash erase/write/suspend host controller.
// Assumes fesc_params.svh is included by the users of the constants.
package fesc_pkg;

    // ===========================================================
    // Host operations that software can order
    typedef enum logic [2:0]
    {
        FESC_OP_NONE,
        FESC_OP_CLEAR,
        FESC_OP_ERASE,
        FESC_OP_WRITE,
        FESC_OP_SUSPEND,
        FESC_OP_RESUME,
        FESC_OP_READ_STATUS,
        FESC_OP_READ_ARRAY
    } fesc_op_t;

    // ===========================================================
    // One bus cycle handed to the strobe engine
    typedef struct packed
    {
        logic is_read;
        logic [20:0] addr;
        logic [7:0] data;
    } fesc_cyc_t;

    // ===========================================================
    // Flash pins driven by the controller
    typedef struct packed
    {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [20:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
    } fesc_pins_t;

endpackage : fesc_pkg

// ===== core/fesc_host.sv
// Host controller for a byte-wide flash: erase, write, suspend, resume.
// Assumes software on Avalon-MM and a flash on synchronous pins.
// Notes on behaviour
// - Clear-status is one write of 50H
// - Erase is setup then confirm in block
// - Write is setup 40H/10H then data
// - Erase suspend allows only listed commands
// - Write suspend allows only listed commands
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "fesc_params.svh"

module fesc_host #(
    parameter int PHASE_CYC = `FESC_PHASE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Flash pins
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic [20:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in,
    input wire logic ready_busy_out
);

    // ===========================================================
    // Reset release
    logic rst_s1_ff, rst_n_ff;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_n_ff <= rst_s1_ff;
        end
    end

    // ===========================================================
    // Strobe engine
    logic eng_start;
    fesc_pkg::fesc_cyc_t eng_cyc;
    logic eng_done;
    logic [7:0] eng_rdata;
    fesc_pkg::fesc_pins_t pins;

    fesc_strobe #(.PHASE_CYC(PHASE_CYC)) u_strobe (
        .clk(clk),
        .rst_n(rst_n_ff),
        .start(eng_start),
        .cyc(eng_cyc),
        .done_ff(eng_done),
        .rdata_ff(eng_rdata),
        .pins_ff(pins),
        .dq_in(flash_dq_in)
    );

    // Pins come straight from the engine's flip-flops
    assign flash_ce_n = pins.ce_n;
    assign flash_we_n = pins.we_n;
    assign flash_oe_n = pins.oe_n;
    assign flash_addr = pins.addr;
    assign flash_dq_out = pins.dq_out;
    assign flash_dq_oe = pins.dq_oe;

    // ===========================================================
    // Sequencer and registers
    typedef enum logic [2:0] {S_IDLE, S_CMD1, S_CMD2, S_READ, S_RESP} s_t;
    s_t st_ff, nxt_st;
    fesc_pkg::fesc_op_t op_ff, nxt_op;
    logic alt_ff, nxt_alt;
    logic [20:0] addr_ff, nxt_addr;
    logic [7:0] data_ff, nxt_data;
    logic [7:0] status_ff, nxt_status;
    logic erase_susp_ff, nxt_erase_susp;
    logic write_susp_ff, nxt_write_susp;
    logic refused_ff, nxt_refused;
    logic [31:0] rdata_ff, nxt_rdata;
    logic wait_ff, nxt_wait;
    logic start_ff, nxt_start;
    fesc_pkg::fesc_cyc_t cyc_ff, nxt_cyc;
    logic wrun_ff, nxt_wrun; // Running operation is a byte write
    logic rb_busy;

    assign eng_start = start_ff;
    assign eng_cyc = cyc_ff;
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign rb_busy = !ready_busy_out; // High while running

    // Operation order and refusal; the host keeps suspend rules itself
    // so software cannot push the flash into an undefined sequence.
    always_comb
    begin
        fesc_pkg::fesc_op_t req;
        req = fesc_pkg::fesc_op_t'(avs_writedata[`FESC_OP_LSB +: 3]);
        nxt_st = st_ff;
        nxt_op = op_ff;
        nxt_alt = alt_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        nxt_status = status_ff;
        nxt_erase_susp = erase_susp_ff;
        nxt_write_susp = write_susp_ff;
        nxt_refused = refused_ff;
        nxt_rdata = rdata_ff;
        nxt_wait = 1'b1;
        nxt_start = 1'b0;
        nxt_cyc = cyc_ff;
        nxt_wrun = wrun_ff;
        case (st_ff)
            S_IDLE:
            begin
                if (avs_read && wait_ff)
                begin
                    nxt_wait = 1'b0;
                    nxt_st = S_RESP;
                    if (avs_address == `FESC_REG_ADDR)
                        nxt_rdata = {11'h0, addr_ff};
                    else if (avs_address == `FESC_REG_DATA)
                        nxt_rdata = {24'h0, data_ff};
                    else if (avs_address == `FESC_REG_STAT)
                        nxt_rdata = {20'h0, refused_ff, write_susp_ff,
                            erase_susp_ff, rb_busy, status_ff};
                    else if (avs_address == `FESC_REG_CTRL)
                        nxt_rdata = {27'h0, alt_ff, 1'b0, op_ff};
                    else
                        nxt_rdata = 32'h0;
                end
                else if (avs_write && wait_ff)
                begin
                    if (avs_address == `FESC_REG_ADDR)
                    begin
                        nxt_addr = avs_writedata[20:0];
                        nxt_wait = 1'b0;
                        nxt_st = S_RESP;
                    end
                    else if (avs_address == `FESC_REG_DATA)
                    begin
                        nxt_data = avs_writedata[7:0];
                        nxt_wait = 1'b0;
                        nxt_st = S_RESP;
                    end
                    else if (avs_address == `FESC_REG_CTRL)
                    begin
                        nxt_op = req;
                        nxt_alt = avs_writedata[`FESC_CTRL_ALT_SETUP];
                        nxt_refused = 1'b0;
                        nxt_cyc.is_read = 1'b0;
                        nxt_cyc.addr = addr_ff;
                        nxt_start = 1'b1;
                        nxt_st = S_CMD1;
                        case (req)
                            fesc_pkg::FESC_OP_CLEAR:
                            begin
                                // Single write
                                nxt_cyc.data = `FESC_CMD_CLEAR_STATUS;
                                if (erase_susp_ff || write_susp_ff)
                                begin
                                    nxt_start = 1'b0;
                                    nxt_refused = 1'b1;
                                end
                            end
                            fesc_pkg::FESC_OP_ERASE:
                            begin
                                nxt_cyc.data = `FESC_CMD_ERASE_SETUP;
                                if (erase_susp_ff || write_susp_ff || rb_busy)
                                begin
                                    nxt_start = 1'b0;
                                    nxt_refused = 1'b1;
                                end
                                else
                                    nxt_wrun = 1'b0;
                            end
                            fesc_pkg::FESC_OP_WRITE:
                            begin
                                if (avs_writedata[`FESC_CTRL_ALT_SETUP])
                                    nxt_cyc.data = `FESC_CMD_WRITE_SETUP_ALT;
                                else
                                    nxt_cyc.data = `FESC_CMD_WRITE_SETUP;
                                if (write_susp_ff || rb_busy)
                                begin
                                    nxt_start = 1'b0;
                                    nxt_refused = 1'b1;
                                end
                                else
                                    nxt_wrun = 1'b1;
                            end
                            fesc_pkg::FESC_OP_SUSPEND:
                            begin
                                nxt_cyc.data = `FESC_CMD_SUSPEND;
                                if (!rb_busy)
                                begin
                                    nxt_start = 1'b0;
                                    nxt_refused = 1'b1;
                                end
                                else if (erase_susp_ff || wrun_ff)
                                    nxt_write_susp = 1'b1;
                                else
                                    nxt_erase_susp = 1'b1;
                            end
                            fesc_pkg::FESC_OP_RESUME:
                            begin
                                nxt_cyc.data = `FESC_CMD_RESUME;
                                if (write_susp_ff)
                                    nxt_write_susp = 1'b0;
                                else if (erase_susp_ff && !rb_busy)
                                begin
                                    nxt_erase_susp = 1'b0;
                                    nxt_wrun = 1'b0;
                                end
                                else
                                begin
                                    nxt_start = 1'b0;
                                    nxt_refused = 1'b1;
                                end
                            end
                            fesc_pkg::FESC_OP_READ_ARRAY:
                            begin
                                nxt_cyc.data = `FESC_CMD_READ_ARRAY;
                                if (rb_busy)
                                begin
                                    nxt_start = 1'b0;
                                    nxt_refused = 1'b1;
                                end
                            end
                            default:
                                nxt_cyc.data = `FESC_CMD_READ_STATUS;
                        endcase
                        if (!nxt_start)
                        begin
                            nxt_wait = 1'b0;
                            nxt_st = S_RESP;
                        end
                    end
                    else
                    begin
                        nxt_wait = 1'b0;
                        nxt_st = S_RESP;
                    end
                end
            end
            S_CMD1:
            begin
                if (eng_done)
                begin
                    nxt_start = 1'b1;
                    if (op_ff == fesc_pkg::FESC_OP_ERASE)
                    begin
                        nxt_cyc.data = `FESC_CMD_CONFIRM;
                        nxt_st = S_CMD2;
                    end
                    else if (op_ff == fesc_pkg::FESC_OP_WRITE)
                    begin
                        nxt_cyc.data = data_ff;
                        nxt_st = S_CMD2;
                    end
                    else
                    begin
                        // Status read-back after command
                        nxt_cyc.is_read = 1'b1;
                        nxt_st = S_READ;
                    end
                end
            end
            S_CMD2:
            begin
                if (eng_done)
                begin
                    nxt_start = 1'b1;
                    nxt_cyc.is_read = 1'b1; // Reads now give status
                    nxt_st = S_READ;
                end
            end
            S_READ:
            begin
                if (eng_done)
                begin
                    // Flags and ready mirrored from flash
                    nxt_status = eng_rdata;
                    nxt_wait = 1'b0;
                    nxt_st = S_RESP;
                end
            end
            default:
                nxt_st = S_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            st_ff <= S_IDLE;
            op_ff <= fesc_pkg::FESC_OP_NONE;
            alt_ff <= 1'b0;
            addr_ff <= 21'h0;
            data_ff <= 8'h00;
            status_ff <= 8'h80;
            erase_susp_ff <= 1'b0;
            write_susp_ff <= 1'b0;
            refused_ff <= 1'b0;
            rdata_ff <= 32'h0;
            wait_ff <= 1'b1;
            start_ff <= 1'b0;
            cyc_ff <= '0;
            wrun_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            op_ff <= nxt_op;
            alt_ff <= nxt_alt;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            status_ff <= nxt_status;
            erase_susp_ff <= nxt_erase_susp;
            write_susp_ff <= nxt_write_susp;
            refused_ff <= nxt_refused;
            rdata_ff <= nxt_rdata;
            wait_ff <= nxt_wait;
            start_ff <= nxt_start;
            cyc_ff <= nxt_cyc;
            wrun_ff <= nxt_wrun;
        end
    end

    // ===========================================================
    // Checks
    sequence clr_req_s;
        st_ff == S_IDLE && avs_write && wait_ff
            && avs_address == `FESC_REG_CTRL
            && avs_writedata[2:0] == 3'(fesc_pkg::FESC_OP_CLEAR);
    endsequence
    clear_block_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
        clr_req_s and (erase_susp_ff || write_susp_ff) |=> !start_ff)
        else $error("clear status sent while suspended");
    erase_pair_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
        st_ff == S_CMD1 && eng_done && op_ff == fesc_pkg::FESC_OP_ERASE
        |=> start_ff && cyc_ff.data == `FESC_CMD_CONFIRM)
        else $error("erase setup not followed by confirm");
    write_data_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
        st_ff == S_CMD1 && eng_done && op_ff == fesc_pkg::FESC_OP_WRITE
        |=> start_ff && cyc_ff.data == data_ff)
        else $error("write setup not followed by data");
    status_read_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
        st_ff == S_CMD2 && eng_done |=> cyc_ff.is_read)
        else $error("no status read after command");
    resume_order_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
        $fell(erase_susp_ff) |-> !$past(write_susp_ff))
        else $error("erase resumed with write suspended");
    array_block_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
        $rose(st_ff == S_CMD1) && op_ff == fesc_pkg::FESC_OP_READ_ARRAY
        |-> !$past(rb_busy))
        else $error("read array sent while busy");
    wsusp_set_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
        $rose(write_susp_ff) |-> erase_susp_ff || $past(rb_busy))
        else $error("write suspend without running operation");
    esusp_set_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
        $rose(erase_susp_ff) |-> $past(rb_busy))
        else $error("erase suspend without running operation");
    wait_release_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
        !wait_ff |=> wait_ff)
        else $error("waitrequest low for more than one cycle");

endmodule : fesc_host

// ===== core/fesc_strobe.sv
// Strobe engine: runs one flash bus cycle, write or read.
// Assumes flash inputs are synchronous to clk and the strobe phase
// length meets the flash setup and pulse widths.
`timescale 1ns/1ps
`include "fesc_params.svh"

module fesc_strobe #(
    parameter int PHASE_CYC = `FESC_PHASE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire fesc_pkg::fesc_cyc_t cyc,
    output logic done_ff,
    output logic [7:0] rdata_ff,
    // Flash pins
    output fesc_pkg::fesc_pins_t pins_ff,
    input wire logic [7:0] dq_in
);

    // ===========================================================
    // Cycle sequencer
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} st_t;
    st_t st_ff, nxt_st;
    logic [7:0] cnt_ff, nxt_cnt;
    logic nxt_done;
    logic [7:0] nxt_rdata;
    fesc_pkg::fesc_pins_t nxt_pins;
    localparam logic [7:0] PH = 8'(PHASE_CYC);

    // Next values; a strobe pulse stays low a full phase so data latch
    // on its rising edge, and output strobe returns high between reads.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_pins = pins_ff;
        case (st_ff)
            ST_IDLE:
            begin
                if (start)
                begin
                    nxt_pins.addr = cyc.addr;
                    nxt_pins.dq_out = cyc.data;
                    nxt_pins.dq_oe = !cyc.is_read;
                    nxt_pins.ce_n = 1'b0;
                    nxt_cnt = 8'h00;
                    nxt_st = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                nxt_cnt = cnt_ff + 8'h01;
                if (cnt_ff + 8'h01 >= PH)
                begin
                    nxt_cnt = 8'h00;
                    if (pins_ff.dq_oe)
                        nxt_pins.we_n = 1'b0;
                    else
                        nxt_pins.oe_n = 1'b0; // Status latched on fall
                    nxt_st = ST_PULSE;
                end
            end
            ST_PULSE:
            begin
                nxt_cnt = cnt_ff + 8'h01;
                if (cnt_ff + 8'h01 >= PH)
                begin
                    nxt_cnt = 8'h00;
                    nxt_rdata = pins_ff.dq_oe ? rdata_ff : dq_in;
                    nxt_pins.we_n = 1'b1; // Latch on rising edge
                    nxt_pins.oe_n = 1'b1; // Return high before next read
                    nxt_st = ST_HOLD;
                end
            end
            default:
            begin
                nxt_cnt = cnt_ff + 8'h01;
                if (cnt_ff + 8'h01 >= PH)
                begin
                    nxt_pins.ce_n = 1'b1;
                    nxt_pins.dq_oe = 1'b0;
                    nxt_done = 1'b1;
                    nxt_st = ST_IDLE;
                end
            end
        endcase
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= ST_IDLE;
            cnt_ff <= 8'h00;
            done_ff <= 1'b0;
            rdata_ff <= 8'h00;
            pins_ff <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 21'h0,
                dq_out: 8'h00, dq_oe: 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
            rdata_ff <= nxt_rdata;
            pins_ff <= nxt_pins;
        end
    end

    // ===========================================================
    // Checks
    write_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pins_ff.we_n) |-> pins_ff.dq_oe && !pins_ff.ce_n)
        else $error("write strobe rose without driven data");
    read_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pins_ff.oe_n) |=> pins_ff.oe_n)
        else $error("output strobe did not stay high between reads");

endmodule : fesc_strobe

// ===== verif/fesc_flash_model.sv
// Flash partner: command interface and status of a byte-wide flash.
// Assumes the host moves its strobes on clk edges.
`timescale 1ns/1ps

module fesc_flash_model #(
    parameter int BUSY = 150
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Flash pins
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [7:0] dq,
    input wire logic dq_oe,
    output logic [7:0] dq_in,
    output logic ready_busy_out
);
    logic [7:0] sr, lat;
    logic [8:0] cnt;
    logic [1:0] pend;
    logic susp, er, we_q, oe_q;
    // Deselected bus shows the inverse so a stale byte never passes
    // A fresh strobe fall shows the status being latched at that edge
    assign dq_in = (!oe_n && !ce_n) ? (oe_q ? sr : lat) : ~lat;
    assign ready_busy_out = !(cnt != 9'h0 && !susp);
    // ==========================================================
    // Command capture on the write strobe rise
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {sr, lat, cnt, pend, susp, er, we_q, oe_q} <= {8'h80, 23'h3};
        end
        else
        begin
            we_q <= we_n;
            oe_q <= oe_n;
            if (cnt != 9'h0 && !susp)
            begin
                cnt <= cnt - 9'h1;
                sr[7] <= (cnt == 9'h1);
            end
            if (!oe_n && oe_q) lat <= sr;
            if (we_n && !we_q && !ce_n && dq_oe)
            begin
                pend <= 2'h0;
                if (pend == 2'h1 && dq != 8'hd0) sr[5:4] <= 2'h3;
                else if (pend != 2'h0)
                begin
                    {cnt, er, sr[7]} <= {9'(BUSY), pend == 2'h1, 1'b0};
                end
                else case (dq)
                    8'h50: if (!susp) sr <= sr & 8'hc4;
                    8'h20: pend <= 2'h1;
                    8'h40, 8'h10: pend <= 2'h2;
                    8'hb0: if (cnt != 9'h0)
                    begin
                        {susp, sr[7], sr[6], sr[2]} <= {2'h3, er, !er};
                    end
                    8'hd0: {susp, sr[7], sr[6], sr[2]} <= 4'h0;
                    default: ;
                endcase
            end
        end
    end
endmodule : fesc_flash_model

// ===== verif/test_flash_erase_write_suspend_control.sv
// Self-checking bench for the flash host controller.
// Assumes the partner model answers every flash strobe cycle.
`timescale 1ns/1ps

module test_flash_erase_write_suspend_control;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic r = 1'b0;
    logic w = 1'b0;
    logic [3:0] a = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata, q;
    logic wr, ce_n, we_n, oe_n, rb, doe;
    logic [7:0] dq, di;
    logic [20:0] fa;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    fesc_host #(.PHASE_CYC(1)) DUT (.clk(clk), .rstn(rstn),
        .avs_address(a), .avs_read(r), .avs_write(w), .avs_writedata(wd),
        .avs_readdata(rdata), .avs_waitrequest(wr), .flash_ce_n(ce_n),
        .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(fa),
        .flash_dq_out(dq), .flash_dq_oe(doe), .flash_dq_in(di),
        .ready_busy_out(rb));
    fesc_flash_model flash (.clk(clk), .rstn(rstn), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .dq(dq), .dq_oe(doe), .dq_in(di),
        .ready_busy_out(rb));
    initial forever #20 clk = ~clk;
    // Hang guard well above the whole sequence
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            errors++;
            test_done();
        end
    end
    // ==========================================================
    // Bus, compare and closing tasks
    task test_done;
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task chk(input string n, input logic [11:0] e);
        samples_checked++;
        if (q[11:0] !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, q[11:0]);
        end
    endtask : chk
    task chk_addr(input logic [20:0] e);
        samples_checked++;
        if (fa !== e)
        begin
            errors++;
            $display("wrong value flash address expected %h seen %h", e, fa);
        end
    endtask : chk_addr
    // Request held until waitrequest low, then a gap before the next
    task bus(input logic wn, input logic [3:0] ad, input logic [31:0] d);
        w <= wn;
        r <= !wn;
        a <= ad;
        wd <= d;
        do @(posedge clk); while (wr !== 1'b0);
        q = rdata;
        w <= 1'b0;
        r <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : bus
    task op(input logic [31:0] c);
        bus(1'b1, 4'h0, c);
        bus(1'b0, 4'hc, 32'h0);
    endtask : op
    task poll;
        for (int i = 0; i < 100 && q[8] !== 1'b0; i++) bus(1'b0, 4'hc, 32'h0);
    endtask : poll
    // ==========================================================
    // Scenarios
    task t_clear;
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 12'h000);
        op(32'h1);
        chk("clear", 12'h080);
    endtask : t_clear
    task t_erase;
        bus(1'b1, 4'h4, 32'h12345);
        bus(1'b0, 4'h4, 32'h0);
        chk("addr reg", 12'h345);
        op(32'h2);
        chk("erase busy", 12'h100);
        chk_addr(21'h12345);
        op(32'h4);
        chk("erase held", 12'h2c0);
        op(32'h1);
        chk("clear in suspend", 12'hac0);
        op(32'h5);
        chk("erase resumed", 12'h100);
        poll;
        op(32'h6);
        chk("erase done", 12'h080);
    endtask : t_erase
    task t_write;
        bus(1'b1, 4'h8, 32'h5a);
        op(32'h13);
        chk("write busy", 12'h100);
        bus(1'b0, 4'h0, 32'h0);
        chk("ctrl reg", 12'h013);
        op(32'h7);
        chk("array while busy", 12'h900);
        op(32'h4);
        chk("write held", 12'h484);
        op(32'h5);
        chk("write resumed", 12'h100);
        poll;
        op(32'h6);
        chk("write done", 12'h080);
        op(32'h7);
        chk("array when idle", 12'h080);
    endtask : t_write
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_clear();
        t_erase();
        t_write();
        test_done();
    end
endmodule : test_flash_erase_write_suspend_control
